/* File: src/vtpc_pkg.sv */
// Purpose: Shared constants for the video test pattern configuration block
// Assumes: Registers are eight bits wide, one per 32-bit Wishbone word
// Notes:   Byte address of a register is four times its index
package vtpc_pkg;
    // Register indices
    localparam logic [7:0] IDX_PORT_CTRL = 8'h60;
    localparam logic [7:0] IDX_STATUS    = 8'h61;
    localparam logic [7:0] IDX_PAT_CTRL  = 8'h62;
    localparam logic [7:0] IDX_CONFIG    = 8'h65;
    localparam logic [7:0] IDX_IND_ADDR  = 8'h66;
    localparam logic [7:0] IDX_IND_DATA  = 8'h67;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // Configuration bit positions
    localparam int CFG_SCALE  = 6;
    localparam int CFG_CUST   = 5;
    localparam int CFG_18B    = 4;
    localparam int CFG_EXTCLK = 3;
    localparam int CFG_TSEL   = 2;
    localparam int CFG_INV    = 1;
    localparam int CFG_ASCRL  = 0;
    // Other control and status fields
    localparam int PAT_EN     = 0;
    localparam int PAT_SEL    = 4;
    localparam int PORT_INDEP = 0;
    localparam int PORT_SEL   = 1;
    localparam int STAT_OVF   = 0;
    localparam int STAT_PAT   = 4;
    // Indirect map
    localparam int IND_DEPTH      = 17;
    localparam int IND_FRAME_TIME = 0;
    localparam int IND_RED        = 1;
    localparam int IND_HTOT       = 4;
    localparam int IND_VTOT       = 6;
    localparam int IND_HACT       = 8;
    localparam int IND_VACT       = 10;
    localparam int IND_HSW        = 12;
    localparam int IND_VSW        = 13;
    localparam int IND_HBP        = 14;
    localparam int IND_VBP        = 15;
    localparam int IND_SYNC       = 16;
    // Pattern codes and colours
    localparam logic [3:0] PAT_CHECKER = 4'h0;
    localparam logic [3:0] PAT_CUSTOM  = 4'he;
    localparam logic [23:0] WHITE      = 24'hffffff;
    localparam logic [23:0] MASK_18B   = 24'hfcfcfc;
    localparam int CNT_W    = 16;
    localparam int PIX_DIV  = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int VID_W    = 51;
endpackage

/* File: src/vtpc_stream_if.sv */
// Purpose: Valid/ready stream between the generator and its FIFO
// Assumes: One word moves on each edge where valid and ready are high
// Notes:   Width is a parameter
`timescale 1ns/10ps
interface vtpc_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: src/vtpc_fifo.sv */
// Purpose: Pixel FIFO with a registered output word
// Assumes: DEPTH is a power of two
// Notes:   Holds DEPTH words plus the word on the output register
`timescale 1ns/10ps
module vtpc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic    mclk,
    input wire logic    sys_rst,
    // Streams
    vtpc_stream_if.snk  in_s,
    vtpc_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             cnt;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic                    ov;
        logic [W-1:0]            od;
    } vtpc_fifo_state_type;
    vtpc_fifo_state_type q, d;
    logic push;
    logic load;

    ////////////////////////////////////////////////////////////////////
    // Ready stays honest: it drops once every slot is taken
    assign in_s.ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_s.valid = q.ov;
    assign out_s.data  = q.od;
    assign push        = in_s.valid & in_s.ready;
    assign load        = (!q.ov || out_s.ready) && (q.cnt != '0);

    // Next state
    always_comb begin
        d = q;
        if (q.ov && out_s.ready) begin
            d.ov = 1'b0;
        end
        if (load) begin
            d.od = q.mem[q.rp];
            d.ov = 1'b1;
            d.rp = AW'(q.rp + 1'b1);
        end
        if (push) begin
            d.mem[q.wp] = in_s.data;
            d.wp        = AW'(q.wp + 1'b1);
        end
        d.cnt = (AW+1)'(q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load});
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

/* File: src/vtpc_top.sv */
// Purpose: Config and indirect front end of a video test pattern generator
// Assumes: Classic Wishbone slave, one 8-bit register per aligned word
// Notes:   Frame timing and clock choice follow port 0's copy
//
// What this block does
// - Scale bit makes checker squares 8x8
// - Custom bit checks custom colour with black
// - 18-bit mode keeps six top colour bits
// - Clock bit picks external or divided clock while timing select on
// - Timing select on: generate own frame timing
// - Timing select off: follow external video timing
// - Inversion bit inverts the output colour
// - Auto-scroll steps pattern after frame count
// - Indirect address holds an 8-bit index
// - Indirect data write stores at address
// - Indirect data read returns addressed byte
// - Independent mode: each port own copy
// - Config register resets to zero
// - Output only while enable bit set
// - Code 1110 draws custom colour or inverse
// - Fixed select ignored during auto-scroll
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
module vtpc_top #(
    parameter int DIV   = vtpc_pkg::PIX_DIV,
    parameter int DEPTH = vtpc_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic         mclk,
    input wire logic         sys_rst,
    // Wishbone slave
    input wire logic         cyc_i,
    input wire logic         stb_i,
    input wire logic         we_i,
    input wire logic [9:0]   adr_i,
    input wire logic [3:0]   sel_i,
    input wire logic [31:0]  dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // External video timing
    input wire logic         ext_pclk,
    input wire logic         ext_de,
    input wire logic         ext_hs,
    input wire logic         ext_vs,
    // Video to the serializer
    output logic             vid_valid,
    input wire logic         vid_ready,
    output logic             vid_de,
    output logic             vid_hs,
    output logic             vid_vs,
    output logic [23:0]      vid_rgb0,
    output logic [23:0]      vid_rgb1
);
    localparam int CW = vtpc_pkg::CNT_W;
    typedef struct packed {
        logic                                   ack;
        logic [31:0]                            rdat;
        logic [1:0][7:0]                        cfg;
        logic [1:0][7:0]                        iaddr;
        logic [1:0][7:0]                        pctl;
        logic [1:0][vtpc_pkg::IND_DEPTH-1:0][7:0] ind;
        logic                                   indep;
        logic                                   psel;
        logic                                   ovf;
        logic [1:0][3:0]                        cur;
        logic [1:0][7:0]                        fcnt;
        logic [CW-1:0]                          h;
        logic [CW-1:0]                          v;
        logic [7:0]                             div;
        logic                                   pend;
        logic                                   pclk_d;
        logic                                   de_d;
        logic                                   vs_d;
    } vtpc_state_type;
    vtpc_state_type q, d;

    vtpc_stream_if #(.W(vtpc_pkg::VID_W)) pix_s ();
    vtpc_stream_if #(.W(vtpc_pkg::VID_W)) vid_s ();

    logic [7:0]     idx;
    logic           req;
    logic           wr;
    logic           s;
    logic           edge_p;
    logic           strobe;
    logic           go;
    logic           tsel;
    logic           frame_evt;
    logic           p_de;
    logic           p_hs;
    logic           p_vs;
    logic [1:0][3:0]  pat;
    logic [1:0][23:0] rgb;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Sixteen-bit value from a pair of indirect bytes on port 0
    function automatic logic [15:0] get16(input vtpc_state_type st, input int i);
        return {st.ind[0][i+1], st.ind[0][i]};
    endfunction

    // Colour of one pixel for a pattern code and a port's config
    function automatic logic [23:0] pat_color(input logic [7:0] c, input logic [3:0] p,
                                              input logic [CW-1:0] x, input logic [CW-1:0] y,
                                              input logic [23:0] cust);
        logic       ck;
        logic       alt;
        logic [7:0] lh;
        logic [7:0] lv;
        logic [23:0] o;
        ck  = c[vtpc_pkg::CFG_SCALE] ? x[3] ^ y[3] : x[0] ^ y[0];
        alt = c[vtpc_pkg::CFG_SCALE] ? x[3] : x[0];
        // 64 steps in 18-bit mode, 256 otherwise
        lh  = c[vtpc_pkg::CFG_18B] ? {x[5:0], 2'b00} : x[7:0];
        lv  = c[vtpc_pkg::CFG_18B] ? {y[5:0], 2'b00} : y[7:0];
        case (p)
            4'h0:    o = ck ? (c[vtpc_pkg::CFG_CUST] ? cust : vtpc_pkg::WHITE) : 24'h000000;
            4'h1:    o = vtpc_pkg::WHITE;
            4'h2:    o = 24'h000000;
            4'h3:    o = 24'hff0000;
            4'h4:    o = 24'h00ff00;
            4'h5:    o = 24'h0000ff;
            4'h6:    o = {lh, lh, lh};
            4'h7:    o = {lh, 16'h0000};
            4'h8:    o = {8'h00, lh, 8'h00};
            4'h9:    o = {16'h0000, lh};
            4'ha:    o = {lv, lv, lv};
            4'hb:    o = {lv, 16'h0000};
            4'hc:    o = {8'h00, lv, 8'h00};
            4'hd:    o = {16'h0000, lv};
            4'he:    o = cust;
            default: o = alt ? vtpc_pkg::WHITE : 24'h000000;
        endcase
        if (c[vtpc_pkg::CFG_INV]) begin
            o = ~o;
        end
        if (c[vtpc_pkg::CFG_18B]) begin
            o = o & vtpc_pkg::MASK_18B;
        end
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus decode and pixel pacing
    assign idx    = adr_i[9:2];
    assign req    = cyc_i & stb_i & ~q.ack;
    assign wr     = req & we_i & sel_i[0];
    assign s      = q.indep ? q.psel : 1'b0;
    assign tsel   = q.cfg[0][vtpc_pkg::CFG_TSEL];
    assign edge_p = ext_pclk & ~q.pclk_d;
    // External clock in external timing, else the clock bit chooses
    assign strobe = (!tsel || q.cfg[0][vtpc_pkg::CFG_EXTCLK]) ? edge_p
                  : (q.div == 8'(DIV - 1));
    // Internal timing stalls on back-pressure; external pixels cannot wait
    assign go     = tsel ? ((strobe | q.pend) & pix_s.ready) : strobe;

    // Sync and enable for the pixel being produced
    always_comb begin
        logic [15:0] ht;
        logic [15:0] vt;
        ht = get16(q, vtpc_pkg::IND_HTOT) - 16'(q.ind[0][vtpc_pkg::IND_HBP]);
        vt = get16(q, vtpc_pkg::IND_VTOT) - 16'(q.ind[0][vtpc_pkg::IND_VBP]);
        if (tsel) begin
            p_de = (q.h < get16(q, vtpc_pkg::IND_HACT))
                 && (q.v < get16(q, vtpc_pkg::IND_VACT));
            p_hs = ((q.h >= ht - 16'(q.ind[0][vtpc_pkg::IND_HSW])) && (q.h < ht))
                 ^ q.ind[0][vtpc_pkg::IND_SYNC][0];
            p_vs = ((q.v >= vt - 16'(q.ind[0][vtpc_pkg::IND_VSW])) && (q.v < vt))
                 ^ q.ind[0][vtpc_pkg::IND_SYNC][1];
            frame_evt = go && (q.h + 16'h0001 >= get16(q, vtpc_pkg::IND_HTOT))
                      && (q.v + 16'h0001 >= get16(q, vtpc_pkg::IND_VTOT));
        end else begin
            p_de = ext_de;
            p_hs = ext_hs;
            p_vs = ext_vs;
            frame_evt = go && ext_vs && !q.vs_d;
        end
    end

    // Pattern per port and its colour
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            pat[p] = q.cfg[p][vtpc_pkg::CFG_ASCRL] ? q.cur[p]
                   : q.pctl[p][vtpc_pkg::PAT_SEL +: 4];
            rgb[p] = q.pctl[p][vtpc_pkg::PAT_EN]
                   ? pat_color(q.cfg[p], pat[p], q.h, q.v,
                               {q.ind[p][1], q.ind[p][2], q.ind[p][3]})
                   : 24'h000000;
        end
    end

    assign pix_s.valid = go && (q.pctl[0][vtpc_pkg::PAT_EN] || q.pctl[1][vtpc_pkg::PAT_EN]);
    assign pix_s.data  = {p_de, p_hs, p_vs, rgb[1], rgb[0]};

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d        = q;
        d.ack    = req;
        d.pclk_d = ext_pclk;
        d.div    = (q.div == 8'(DIV - 1)) ? 8'h00 : 8'(q.div + 8'h01);
        d.pend   = tsel & (strobe | q.pend) & ~pix_s.ready;
        // Register writes land on the selected port or on both
        for (int p = 0; p < 2; p++) begin
            if (wr && (!q.indep || q.psel == p[0])) begin
                case (idx)
                    vtpc_pkg::IDX_CONFIG:   d.cfg[p]   = dat_i[7:0];
                    vtpc_pkg::IDX_IND_ADDR: d.iaddr[p] = dat_i[7:0];
                    vtpc_pkg::IDX_PAT_CTRL: d.pctl[p]  = dat_i[7:0];
                    vtpc_pkg::IDX_IND_DATA: begin
                        if (q.iaddr[p] < 8'(vtpc_pkg::IND_DEPTH)) begin
                            d.ind[p][q.iaddr[p]] = dat_i[7:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (wr && idx == vtpc_pkg::IDX_PORT_CTRL) begin
            d.indep = dat_i[vtpc_pkg::PORT_INDEP];
            d.psel  = dat_i[vtpc_pkg::PORT_SEL];
        end
        // Overflow: set beats a write-one clear
        if (wr && idx == vtpc_pkg::IDX_STATUS && dat_i[vtpc_pkg::STAT_OVF]) begin
            d.ovf = 1'b0;
        end
        if (go && !tsel && !pix_s.ready && pix_s.valid) begin
            d.ovf = 1'b1;
        end
        // Read data, unmapped words read zero
        d.rdat = 32'h00000000;
        if (req && !we_i) begin
            case (idx)
                vtpc_pkg::IDX_CONFIG:    d.rdat[7:0] = q.cfg[s];
                vtpc_pkg::IDX_IND_ADDR:  d.rdat[7:0] = q.iaddr[s];
                vtpc_pkg::IDX_PAT_CTRL:  d.rdat[7:0] = q.pctl[s];
                vtpc_pkg::IDX_PORT_CTRL: d.rdat[7:0] = {6'h00, q.psel, q.indep};
                vtpc_pkg::IDX_STATUS:    d.rdat[7:0] = {q.cur[s], 3'b000, q.ovf};
                vtpc_pkg::IDX_IND_DATA: begin
                    if (q.iaddr[s] < 8'(vtpc_pkg::IND_DEPTH)) begin
                        d.rdat[7:0] = q.ind[s][q.iaddr[s]];
                    end
                end
                default: ;
            endcase
        end
        // Raster position
        if (go) begin
            d.de_d = ext_de;
            d.vs_d = ext_vs;
            if (tsel) begin
                if (q.h + 16'h0001 >= get16(q, vtpc_pkg::IND_HTOT)) begin
                    d.h = '0;
                    d.v = (q.v + 16'h0001 >= get16(q, vtpc_pkg::IND_VTOT)) ? '0 : CW'(q.v + 16'h0001);
                end else begin
                    d.h = CW'(q.h + 16'h0001);
                end
            end else begin
                d.h = ext_de ? CW'(q.h + 16'h0001) : '0;
                d.v = ext_vs ? '0 : ((q.de_d && !ext_de) ? CW'(q.v + 16'h0001) : q.v);
            end
        end
        // Auto-scroll: count frames, then step to the next pattern
        for (int p = 0; p < 2; p++) begin
            if (!q.cfg[p][vtpc_pkg::CFG_ASCRL]) begin
                d.cur[p]  = q.pctl[p][vtpc_pkg::PAT_SEL +: 4];
                d.fcnt[p] = 8'h00;
            end else if (frame_evt) begin
                if (q.fcnt[p] + 8'h01 >= q.ind[p][vtpc_pkg::IND_FRAME_TIME]) begin
                    d.fcnt[p] = 8'h00;
                    d.cur[p]  = 4'(q.cur[p] + 4'h1);
                end else begin
                    d.fcnt[p] = 8'(q.fcnt[p] + 8'h01);
                end
            end
        end
    end

    // State register, everything resets to zero
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pixel FIFO and outputs
    vtpc_fifo #(.W(vtpc_pkg::VID_W), .DEPTH(DEPTH)) u_fifo (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .in_s    (pix_s),
        .out_s   (vid_s)
    );
    assign vid_s.ready = vid_ready;
    assign vid_valid   = vid_s.valid;
    assign {vid_de, vid_hs, vid_vs, vid_rgb1, vid_rgb0} = vid_s.data;
    assign ack_o       = q.ack;
    assign dat_o       = q.rdat;

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_CFG_RESET: assert property (@(posedge mclk)
        $past(sys_rst) && !sys_rst |-> q.cfg == '0 && q.cur == '0)
        else $error("config not zero after reset");
    AST_IND_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
        wr && idx == vtpc_pkg::IDX_IND_DATA && !q.indep && q.iaddr[0] == 8'h01
        |=> q.ind[0][1] == $past(dat_i[7:0]))
        else $error("indirect write lost");
    AST_IND_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        req && !we_i && idx == vtpc_pkg::IDX_IND_DATA && q.iaddr[s] == 8'h02
        |=> ack_o && dat_o[7:0] == $past(q.ind[s][2]))
        else $error("indirect read wrong");
    AST_OFF_BLACK: assert property (@(posedge mclk) disable iff (sys_rst)
        pix_s.valid && !q.pctl[1][vtpc_pkg::PAT_EN] |-> rgb[1] == 24'h000000)
        else $error("disabled port drives colour");
    AST_CUSTOM: assert property (@(posedge mclk) disable iff (sys_rst)
        pix_s.valid && q.pctl[0][vtpc_pkg::PAT_EN] && pat[0] == vtpc_pkg::PAT_CUSTOM
        && q.cfg[0][vtpc_pkg::CFG_INV] && !q.cfg[0][vtpc_pkg::CFG_18B]
        |-> rgb[0] == ~{q.ind[0][1], q.ind[0][2], q.ind[0][3]})
        else $error("inverted custom colour wrong");
    AST_CHECKER: assert property (@(posedge mclk) disable iff (sys_rst)
        pix_s.valid && q.pctl[0][vtpc_pkg::PAT_EN] && pat[0] == vtpc_pkg::PAT_CHECKER && q.cfg[0][6:1] == 6'h22
        |-> rgb[0] == ((q.h[3] ^ q.v[3]) ? vtpc_pkg::WHITE : 24'h000000))
        else $error("scaled checker wrong");
    AST_DEPTH18: assert property (@(posedge mclk) disable iff (sys_rst)
        q.cfg[0][vtpc_pkg::CFG_18B] |-> (rgb[0] & 24'h030303) == 24'h000000)
        else $error("low bits set in 18-bit mode");
    AST_SCROLL: assert property (@(posedge mclk) disable iff (sys_rst)
        !q.cfg[0][vtpc_pkg::CFG_ASCRL] ##1 !q.cfg[0][vtpc_pkg::CFG_ASCRL]
        |-> q.cur[0] == $past(q.pctl[0][7:4]))
        else $error("pattern not held at fixed select");
    AST_STALL: assert property (@(posedge mclk) disable iff (sys_rst)
        tsel && !pix_s.ready ##1 tsel |-> $stable(q.h) && $stable(q.v))
        else $error("raster moved under back-pressure");
endmodule

/* File: dv/vtpc_sink_model.sv */
// Purpose: Serializer-side sink for the generator's video stream
// Assumes: A word is taken on each edge with valid and ready high
// Notes:   Stalls 64 cycles in 512 so that the FIFO fills up
`timescale 1ns/10ps
module vtpc_sink_model (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // Stream from the block
    input wire logic        vid_valid,
    input wire logic        vid_de,
    input wire logic [23:0] vid_rgb0,
    input wire logic [23:0] vid_rgb1,
    output logic            vid_ready,
    // Last active pixel taken
    output logic            de_seen,
    output logic [23:0]     rgb_seen,
    output logic [23:0]     rgb1_seen
);
    logic [8:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Take words and keep the last active pixel
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q     <= 9'h000;
            de_seen   <= 1'b0;
            rgb_seen  <= 24'h000000;
            rgb1_seen <= 24'h000000;
        end else begin
            cnt_q   <= cnt_q + 9'h001;
            de_seen <= vid_valid & vid_ready & vid_de;
            if (vid_valid && vid_ready && vid_de) begin
                rgb_seen  <= vid_rgb0;
                rgb1_seen <= vid_rgb1;
            end
        end
    end

    // A long stall fills the FIFO, so an internally timed raster has to wait for the sink
    assign vid_ready = ~sys_rst & (cnt_q[8:6] != 3'b111);
endmodule

/* File: dv/tb_video_test_pattern_config.sv */
// Purpose: Self-checking bench for the pattern configuration front end
// Assumes: Register index i sits at byte address 4*i
// Notes:   External timing comes from a free-running counter
`timescale 1ns/10ps
module tb_video_test_pattern_config;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o, vid_valid, vid_ready, vid_de, de_seen;
    logic [23:0] vid_rgb0, rgb_seen, vid_rgb1, rgb1_seen;
    logic [31:0] rd;
    logic [7:0]  ext_cnt = 8'h00;
    logic [7:0]  tbl [16] = '{8'h12, 8'h34, 8'h56, 8'h10, 8'h00, 8'h08, 8'h00, 8'h08,
                              8'h00, 8'h04, 8'h00, 8'h02, 8'h01, 8'h02, 8'h01, 8'h00};
    int          fail_count = 0;
    int          checks_done = 0;
    int          n;

    always #2.5 mclk = ~mclk;

    // External raster: a pixel every 8 cycles, active in the upper half
    always @(posedge mclk) begin
        ext_cnt <= ext_cnt + 8'h01;
    end

    vtpc_top dut (.mclk(mclk), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .ext_pclk(ext_cnt[2]), .ext_de(ext_cnt[7]),
        .ext_hs(ext_cnt[6]), .ext_vs(ext_cnt[7:3] == 5'h00), .vid_valid(vid_valid), .vid_ready(vid_ready),
        .vid_de(vid_de), .vid_hs(), .vid_vs(), .vid_rgb0(vid_rgb0), .vid_rgb1(vid_rgb1));

    vtpc_sink_model sink (.mclk(mclk), .sys_rst(sys_rst), .vid_valid(vid_valid), .vid_de(vid_de),
        .vid_rgb0(vid_rgb0), .vid_rgb1(vid_rgb1), .vid_ready(vid_ready), .de_seen(de_seen),
        .rgb_seen(rgb_seen), .rgb1_seen(rgb1_seen));

    ////////////////////////////////////////////////////////////////////////////
    // Compare, report and finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("mismatches %0d checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One classic cycle; held until ack is sampled, then released a cycle
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, wd};
        do begin
            @(posedge mclk);
            k++;
        end while (ack_o !== 1'b1 && k < 100);
        if (k >= 100) fail_count++;
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge mclk);
    endtask

    // Stale words may still drain, so wait for the wanted colour
    task automatic expect_rgb(input logic [23:0] exp);
        int k;
        k = 0;
        while (!(de_seen === 1'b1 && rgb_seen === exp) && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        check({8'h0, rgb_seen}, {8'h0, exp});
    endtask

    // Words taken by the sink over a fixed window
    task automatic count_words(output int c);
        c = 0;
        repeat (400) begin
            @(posedge mclk);
            if (vid_valid === 1'b1 && vid_ready === 1'b1) c++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the few frames the tests need
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int i = 8'h65; i <= 8'h67; i++) begin
            wb(1'b0, i[7:0], 8'h00);
            check(rd, 32'h00);
        end
        wb(1'b1, 8'h65, 8'hff);
        wb(1'b0, 8'h65, 8'h00);
        check(rd, 32'hff);
        wb(1'b1, 8'h70, 8'h33);
        wb(1'b0, 8'h70, 8'h00);
        check(rd, 32'h00);
        // Address is written before every data access
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, 8'h66, 8'(i + 1));
            wb(1'b1, 8'h67, tbl[i]);
        end
        wb(1'b0, 8'h66, 8'h00);
        check(rd, 32'h10);
        wb(1'b1, 8'h66, 8'h02);
        wb(1'b0, 8'h67, 8'h00);
        check(rd, 32'h34);
        wb(1'b1, 8'h65, 8'h04);
        wb(1'b1, 8'h62, 8'he1);
        expect_rgb(24'h123456);
        check({8'h0, rgb1_seen}, 32'h123456);
        wb(1'b1, 8'h65, 8'h06);
        expect_rgb(24'hedcba9);
        wb(1'b1, 8'h65, 8'h14);
        expect_rgb(24'h103454);
        wb(1'b1, 8'h65, 8'h00);
        expect_rgb(24'h123456);
        // External clock paces at one in 8, the divider at one in 4
        wb(1'b1, 8'h65, 8'h0c);
        count_words(n);
        check(32'(n > 38 && n < 62), 32'h1);
        wb(1'b1, 8'h65, 8'h04);
        count_words(n);
        check(32'(n > 80 && n < 110), 32'h1);
        // Frames of 512 cycles with output off, so nothing stalls them
        wb(1'b1, 8'h62, 8'h00);
        wb(1'b1, 8'h66, 8'h08);
        wb(1'b1, 8'h67, 8'h10);
        wb(1'b1, 8'h66, 8'h00);
        wb(1'b1, 8'h67, 8'h02);
        wb(1'b1, 8'h65, 8'h05);
        repeat (100) @(posedge mclk);
        wb(1'b0, 8'h61, 8'h00);
        n = rd;
        repeat (1021) @(posedge mclk);
        wb(1'b0, 8'h61, 8'h00);
        check({28'h0, rd[7:4]}, {28'h0, 4'(n[7:4] + 4'h1)});
        wb(1'b1, 8'h65, 8'h44);
        wb(1'b1, 8'h62, 8'h01);
        expect_rgb(24'hffffff);
        wb(1'b1, 8'h65, 8'h24);
        wb(1'b1, 8'h62, 8'h01);
        expect_rgb(24'h123456);
        wb(1'b1, 8'h62, 8'h00);
        repeat (100) @(posedge mclk);
        n = 0;
        repeat (300) begin
            @(posedge mclk);
            if (vid_valid === 1'b1) n++;
        end
        check(n, 32'h0);
        wb(1'b1, 8'h60, 8'h03);
        wb(1'b1, 8'h65, 8'h5a);
        wb(1'b1, 8'h60, 8'h01);
        wb(1'b0, 8'h65, 8'h00);
        check(rd, 32'h24);
        wb(1'b1, 8'h60, 8'h03);
        wb(1'b0, 8'h65, 8'h00);
        check(rd, 32'h5a);
        wb(1'b1, 8'h60, 8'h01);
        wb(1'b1, 8'h62, 8'he1);
        expect_rgb(24'h123456);
        check({8'h0, rgb1_seen}, 32'h0);
        stop_test();
    end
endmodule
